// File: cmp_b_ctrl.sv
// Control and status logic for the second voltage comparator.
// Assumes an analog core supplying an asynchronous output level and a
// simple register port: strobes one cycle, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none

module cmp_b_ctrl (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [7:0]               addr_i,
    input  wire logic [7:0]               wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output var  logic [7:0]               rdata_o,
    input  wire logic                     cmp_raw_i,
    output var  cmp_b_pkg::analog_cfg_s   analog_cfg_o,
    output var  logic                     cmp_b_routed_out_o,
    output var  logic                     irq_o
);

    // Registered fields
    logic       cmp_b_enable;
    logic       cmp_b_rise_flag;
    logic       cmp_b_fall_flag;
    logic [1:0] cmp_b_pos_hyst_sel;
    logic [1:0] cmp_b_neg_hyst_sel;
    logic       cmp_b_rise_irq_en;
    logic       cmp_b_fall_irq_en;
    logic [1:0] cmp_b_response_mode;
    logic       out_prev;
    logic [7:0] rdata;

    logic       next_enable;
    logic       next_rise_flag;
    logic       next_fall_flag;
    logic [1:0] next_pos_hyst;
    logic [1:0] next_neg_hyst;
    logic       next_rise_irq_en;
    logic       next_fall_irq_en;
    logic [1:0] next_response_mode;
    logic       next_out_prev;
    logic [7:0] next_rdata;

    logic       cmp_sync;
    logic       cmp_b_output_state;
    logic       rise_evt;
    logic       fall_evt;
    logic       wr_ctrl;
    logic       wr_mode;
    logic [7:0] ctrl_view;
    logic [7:0] mode_view;

    // Comparator output brought into the core clock domain
    cmp_b_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (cmp_raw_i),
        .sync_o     (cmp_sync)
    );

    // forced low
    // Output state reads low while the comparator is shut down
    assign cmp_b_output_state = cmp_b_enable & cmp_sync;

    // edge detect
    // Edges only count while enabled, which also suspends interrupts
    assign rise_evt = cmp_b_enable &  cmp_b_output_state & ~out_prev;
    assign fall_evt = cmp_b_enable & ~cmp_b_output_state &  out_prev;

    // Address decode
    assign wr_ctrl = wr_i && (addr_i == cmp_b_pkg::CTRL_OFFSET);
    assign wr_mode = wr_i && (addr_i == cmp_b_pkg::MODE_OFFSET);

    // Register views as software sees them
    always_comb begin
        ctrl_view = cmp_b_pkg::DATA_ZERO;
        ctrl_view[cmp_b_pkg::CTRL_EN_BIT]   = cmp_b_enable;
        ctrl_view[cmp_b_pkg::CTRL_OUT_BIT]  = cmp_b_output_state;
        ctrl_view[cmp_b_pkg::CTRL_RISE_BIT] = cmp_b_rise_flag;
        ctrl_view[cmp_b_pkg::CTRL_FALL_BIT] = cmp_b_fall_flag;
        ctrl_view[cmp_b_pkg::CTRL_HYP_LSB +: 2] = cmp_b_pos_hyst_sel;
        ctrl_view[cmp_b_pkg::CTRL_HYN_LSB +: 2] = cmp_b_neg_hyst_sel;
        mode_view = cmp_b_pkg::DATA_ZERO;
        mode_view[cmp_b_pkg::MODE_RIE_BIT] = cmp_b_rise_irq_en;
        mode_view[cmp_b_pkg::MODE_FIE_BIT] = cmp_b_fall_irq_en;
        mode_view[cmp_b_pkg::MODE_RESP_LSB +: 2] = cmp_b_response_mode;
    end

    // Next values of the enable, hysteresis and mode fields
    always_comb begin
        next_enable        = cmp_b_enable;
        next_pos_hyst      = cmp_b_pos_hyst_sel;
        next_neg_hyst      = cmp_b_neg_hyst_sel;
        next_rise_irq_en   = cmp_b_rise_irq_en;
        next_fall_irq_en   = cmp_b_fall_irq_en;
        next_response_mode = cmp_b_response_mode;
        if (wr_ctrl) begin
            next_enable   = wdata_i[cmp_b_pkg::CTRL_EN_BIT];
            next_pos_hyst = wdata_i[cmp_b_pkg::CTRL_HYP_LSB +: 2];
            next_neg_hyst = wdata_i[cmp_b_pkg::CTRL_HYN_LSB +: 2];
        end
        if (wr_mode) begin
            next_rise_irq_en   = wdata_i[cmp_b_pkg::MODE_RIE_BIT];
            next_fall_irq_en   = wdata_i[cmp_b_pkg::MODE_FIE_BIT];
            next_response_mode = wdata_i[cmp_b_pkg::MODE_RESP_LSB +: 2];
        end
    end

    // Register the configuration fields
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cmp_b_enable <= cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_EN_BIT];
            cmp_b_pos_hyst_sel <=
                cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_HYP_LSB +: 2];
            cmp_b_neg_hyst_sel <=
                cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_HYN_LSB +: 2];
            cmp_b_rise_irq_en <=
                cmp_b_pkg::MODE_RESET[cmp_b_pkg::MODE_RIE_BIT];
            cmp_b_fall_irq_en <=
                cmp_b_pkg::MODE_RESET[cmp_b_pkg::MODE_FIE_BIT];
            cmp_b_response_mode <= cmp_b_pkg::RESP_RESET;
        end else begin
            cmp_b_enable        <= next_enable;
            cmp_b_pos_hyst_sel  <= next_pos_hyst;
            cmp_b_neg_hyst_sel  <= next_neg_hyst;
            cmp_b_rise_irq_en   <= next_rise_irq_en;
            cmp_b_fall_irq_en   <= next_fall_irq_en;
            cmp_b_response_mode <= next_response_mode;
        end
    end

    // Next values of the sticky edge flags and the edge history
    // History tracks the gated level, so enabling while the comparator
    // is already high counts as a rising edge; software clears it
    always_comb begin
        next_rise_flag = cmp_b_rise_flag;
        next_fall_flag = cmp_b_fall_flag;
        next_out_prev  = cmp_b_output_state;
        if (wr_ctrl) begin
            next_rise_flag = wdata_i[cmp_b_pkg::CTRL_RISE_BIT];
            next_fall_flag = wdata_i[cmp_b_pkg::CTRL_FALL_BIT];
        end
        // set wins
        // A hardware edge overrides a clear in the same cycle
        if (rise_evt) begin
            next_rise_flag = 1'b1;
        end
        if (fall_evt) begin
            next_fall_flag = 1'b1;
        end
    end

    // Register the flags and the previous output level
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cmp_b_rise_flag <= cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_RISE_BIT];
            cmp_b_fall_flag <= cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_FALL_BIT];
            out_prev        <= cmp_b_pkg::CTRL_RESET[cmp_b_pkg::CTRL_OUT_BIT];
        end else begin
            cmp_b_rise_flag <= next_rise_flag;
            cmp_b_fall_flag <= next_fall_flag;
            out_prev        <= next_out_prev;
        end
    end

    // Read data: the addressed view for one cycle, zero otherwise
    // Unmapped addresses read as zero
    always_comb begin
        next_rdata = cmp_b_pkg::DATA_ZERO;
        if (rd_i) begin
            if (addr_i == cmp_b_pkg::CTRL_OFFSET) begin
                next_rdata = ctrl_view;
            end else if (addr_i == cmp_b_pkg::MODE_OFFSET) begin
                next_rdata = mode_view;
            end
        end
    end

    // Register the read data
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata <= cmp_b_pkg::DATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Outputs: read data, analog settings, routed output
    // no reset output
    always_comb begin
        rdata_o                    = rdata;
        analog_cfg_o.enable        = cmp_b_enable;
        analog_cfg_o.pos_hyst      = cmp_b_pos_hyst_sel;
        analog_cfg_o.neg_hyst      = cmp_b_neg_hyst_sel;
        analog_cfg_o.response_mode = cmp_b_response_mode;
        cmp_b_routed_out_o         = cmp_b_output_state;
    end

    assign irq_o = cmp_b_enable &
                   ((cmp_b_rise_flag & cmp_b_rise_irq_en) |
                    (cmp_b_fall_flag & cmp_b_fall_irq_en));

endmodule

`default_nettype wire

// File: cmp_b_pkg.sv
// Package for the second comparator control block: offsets, fields, resets.
// Assumes an 8-bit register port driven by a single-clock core.
`default_nettype none

package cmp_b_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] MODE_OFFSET = 8'h89;
    localparam logic [7:0] CTRL_OFFSET = 8'h8A;

    // Control register field positions
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_OUT_BIT  = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB  = 2;
    localparam int CTRL_HYN_LSB  = 0;

    // Mode register field positions
    localparam int MODE_RIE_BIT  = 5;
    localparam int MODE_FIE_BIT  = 4;
    localparam int MODE_RESP_LSB = 0;

    // Values after reset
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] RESP_RESET = 2'h2;
    localparam logic [7:0] DATA_ZERO  = 8'h00;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Settings handed to the analog core
    typedef struct packed {
        logic       enable;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic [1:0] response_mode;
    } analog_cfg_s;

endpackage

`default_nettype wire

// File: cmp_b_sync.sv
// Two-flop level synchroniser for the comparator output.
// Assumes the input is asynchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module cmp_b_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output var  logic sync_o
);

    logic stage_a;
    logic next_stage_a;
    logic next_sync;

    // Next values of both stages
    always_comb begin
        next_stage_a = rst_n_i ? async_i : 1'b0;
        next_sync    = rst_n_i ? stage_a : 1'b0;
    end

    // Register the two stages
    always_ff @(posedge core_clk_i) begin
        stage_a <= next_stage_a;
        sync_o  <= next_sync;
    end

endmodule

`default_nettype wire

// File: cmp_b_ctrl_monitor.sv
// Checker for the second comparator control block.
// Assumes binding to cmp_b_ctrl ports, one clock.
`timescale 1ns/1ps
`default_nettype none

module cmp_b_ctrl_monitor (
    input wire logic                   core_clk_i,
    input wire logic                   rst_n_i,
    input wire logic [7:0]             addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    input wire logic                   cmp_raw_i,
    input wire cmp_b_pkg::analog_cfg_s analog_cfg_o,
    input wire logic                   cmp_b_routed_out_o,
    input wire logic                   irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Register port fields
    chk_mode_reserved: assert property (
        rd_i && addr_i == 8'h89 |=> (rdata_o & 8'hCC) == 8'h00)
        else $error("mode reserved bits not zero");
    chk_resp_write: assert property (
        wr_i && addr_i == 8'h89
        |=> analog_cfg_o.response_mode == $past(wdata_i[1:0]))
        else $error("response mode not taken");
    chk_neg_hyst: assert property (
        wr_i && addr_i == 8'h8A
        |=> analog_cfg_o.neg_hyst == $past(wdata_i[1:0]))
        else $error("negative hysteresis not taken");
    chk_en_write: assert property (
        wr_i && addr_i == 8'h8A |=> analog_cfg_o.enable == $past(wdata_i[7]))
        else $error("enable not taken");
    chk_reset_cfg: assert property (
        $rose(rst_n_i) |-> analog_cfg_o == 7'b000_0010)
        else $error("config wrong after reset");
    // Output and request while disabled, output following the comparator while enabled
    chk_out_off: assert property (
        !analog_cfg_o.enable |-> !cmp_b_routed_out_o)
        else $error("output high while disabled");
    chk_irq_off: assert property (
        !analog_cfg_o.enable |-> !irq_o)
        else $error("request while disabled");
    chk_out_follow: assert property (
        analog_cfg_o.enable [*3] |-> cmp_b_routed_out_o == $past(cmp_raw_i, 2))
        else $error("output does not follow comparator");
endmodule

bind cmp_b_ctrl cmp_b_ctrl_monitor mon (.core_clk_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .cmp_raw_i, .analog_cfg_o,
    .cmp_b_routed_out_o, .irq_o);

`default_nettype wire

// File: cmp_b_ctrl_bench.sv
// Testbench for the second comparator control block.
// Assumes cmp_b_ctrl with its checker bound; 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end

module cmp_b_ctrl_bench;
    logic                   core_clk_i;
    logic                   rst_n_i;
    logic [7:0]             addr_i;
    logic [7:0]             wdata_i;
    logic                   wr_i;
    logic                   rd_i;
    logic [7:0]             rdata_o;
    logic                   cmp_raw_i;
    cmp_b_pkg::analog_cfg_s analog_cfg_o;
    logic                   cmp_b_routed_out_o;
    logic                   irq_o;
    logic [7:0]             exp_q[$];
    logic [7:0]             e_t;
    logic [7:0]             d;
    logic                   rd_q;
    int                     err_count = 0;
    int                     total_checks = 0;

    cmp_b_ctrl uut (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .cmp_raw_i, .analog_cfg_o, .cmp_b_routed_out_o, .irq_o);

    // Clock
    initial begin
        core_clk_i = 0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // One bus cycle, taken at the next edge
    task automatic bus(input logic w, r, input logic [7:0] a, dv);
        @(posedge core_clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= dv;
    endtask

    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        bus(0, 1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        repeat (n) bus(0, 0, 8'h00, 8'h00);
        #1;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Read data compared with the oldest note
    always @(posedge core_clk_i) begin
        rd_q <= rd_i;
        if (rd_q === 1'b1) begin
            e_t = exp_q.pop_front();
            `CHK("rdata", e_t, rdata_o)
        end
    end

    // Watchdog
    initial begin
        repeat (400) @(posedge core_clk_i);
        err_count++;
        test_done();
    end

    initial begin
        {wr_i, rd_i, addr_i, wdata_i, cmp_raw_i, rst_n_i} = '0;
        void'($urandom(32'h3692));
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1;
        rd(8'h89, 8'h02);
        rd(8'h8A, 8'h00);
        bus(1, 0, 8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        rd(8'h89, 8'h02);
        idle(2);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            d = 8'($urandom());
            d[1:0] = 2'(m);
            bus(1, 0, 8'h89, d);
            rd(8'h89, d & 8'h33);
            idle(1);
            `CHK("mode", 2'(m), analog_cfg_o.response_mode)
        end
        d = 8'($urandom()) & 8'h0F;
        bus(1, 0, 8'h8A, d);
        rd(8'h8A, d);
        idle(1);
        `CHK("hyst", d[3:0], analog_cfg_o[5:2])
        $display("test modes done");
        bus(1, 0, 8'h8A, 8'h80);
        bus(1, 0, 8'h8A, 8'h80);
        bus(1, 0, 8'h89, 8'h32);
        cmp_raw_i <= 1;
        idle(5);
        `CHK("irq", 1'b1, irq_o)
        `CHK("out", 1'b1, cmp_b_routed_out_o)
        rd(8'h8A, 8'hE0);
        bus(1, 0, 8'h8A, 8'h80);
        cmp_raw_i <= 0;
        idle(5);
        `CHK("irq", 1'b1, irq_o)
        rd(8'h8A, 8'h90);
        bus(1, 0, 8'h89, 8'h22);
        idle(1);
        `CHK("irq", 1'b0, irq_o)
        bus(1, 0, 8'h89, 8'h12);
        bus(1, 0, 8'h8A, 8'h80);
        cmp_raw_i <= 1;
        idle(5);
        `CHK("irq", 1'b0, irq_o)
        rd(8'h8A, 8'hE0);
        bus(1, 0, 8'h89, 8'h32);
        idle(1);
        `CHK("irq", 1'b1, irq_o)
        bus(1, 0, 8'h8A, 8'h30);
        idle(1);
        `CHK("irq", 1'b0, irq_o)
        bus(1, 0, 8'h8A, 8'h00);
        cmp_raw_i <= 0;
        idle(5);
        rd(8'h8A, 8'h00);
        idle(2);
        $display("test edges done");
        test_done();
    end
endmodule

`default_nettype wire
